/* flash_self_program_sequencer.sv */
/*
 Flash self-programming sequencer: a Wishbone slave holding the control,
 unlock key and 24-bit target address registers, and a timer that runs one
 page erase or one double-word program while stalling the processor.
 Assumes the flash array itself is driven from FLASH_* outputs and that
 the processor honours CPU_STALL.
*/
`timescale 1ns/100ps
module flash_self_program_sequencer
    import nv_seq_pkg::*;
#(
    parameter int ERASE_COUNT   = ERASE_CYCLES,
    parameter int PROGRAM_COUNT = PROGRAM_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    output logic             CPU_STALL,
    output logic             FLASH_ERASE,
    output logic             FLASH_PROGRAM,
    output logic      [23:0] FLASH_ADDR
);

    ////////////////////////////////////////////////////////////////////////
    // Operation decoding shared by the launch check and the sequencer
    function automatic logic is_erase(input logic [31:0] data);
        return data[OP_LSB +: OP_WIDTH] == OP_ERASE;
    endfunction : is_erase

    function automatic logic is_program(input logic [31:0] data);
        return data[OP_LSB +: OP_WIDTH] == OP_PROGRAM;
    endfunction : is_program

    // A word pair must start at an address whose low two bits are 2
    function automatic logic pair_aligned(input logic [23:0] addr);
        return addr[1:0] == 2'h2;
    endfunction : pair_aligned

    ////////////////////////////////////////////////////////////////////////
    seq_state_e  state;
    seq_state_e  next_state;
    key_state_e  key;
    key_state_e  next_key;
    logic [15:0] control;
    logic [15:0] next_control;
    logic [7:0]  addr_hi;
    logic [7:0]  next_addr_hi;
    logic [15:0] addr_lo;
    logic [15:0] next_addr_lo;
    logic [31:0] timer;
    logic [31:0] next_timer;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        access;
    logic        wr;
    logic        wr_control;
    logic        wr_key;
    logic        wr_addr_hi;
    logic        wr_addr_lo;
    logic        idle;
    logic        launch;
    logic        finish;
    logic [23:0] target_address;

    // Only the low two lanes are implemented; a write needs both lanes
    assign access     = CYC_I && STB_I && !ACK_O;
    assign wr         = access && WE_I && SEL_I[0] && SEL_I[1];
    assign wr_control = wr && (ADR_I == OFS_CONTROL);
    assign wr_key     = wr && (ADR_I == OFS_KEY);
    assign wr_addr_hi = wr && (ADR_I == OFS_ADDR_HI);
    assign wr_addr_lo = wr && (ADR_I == OFS_ADDR_LO);
    assign idle       = (state == ST_IDLE);
    assign target_address = {addr_hi, addr_lo};
    assign finish     = !idle && (timer == 32'h0);

    // Launch needs enable, a valid op, an armed key and a legal alignment
    always_comb begin
        launch = 1'b0;
        if (wr_control && DAT_I[START_BIT] && DAT_I[ENABLE_BIT] && idle
            && key == KEY_ARMED) begin
            if (is_erase(DAT_I))
                launch = 1'b1;
            else if (is_program(DAT_I) && pair_aligned(target_address))
                launch = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unlock tracking: any other write in between throws the key away,
    // and a launch consumes it so a second start needs a fresh unlock
    always_comb begin
        next_key = key;
        if (launch) begin
            next_key = KEY_NONE;
        end else if (wr) begin
            if (wr_key && DAT_I[7:0] == KEY_FIRST)
                next_key = KEY_HALF;
            else if (wr_key && DAT_I[7:0] == KEY_SECOND && key == KEY_HALF)
                next_key = KEY_ARMED;
            else
                next_key = KEY_NONE;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            key <= KEY_NONE;
        else
            key <= next_key;
    end

    ////////////////////////////////////////////////////////////////////////
    // Target address; frozen while an operation runs so the flash array
    // never sees its address move under it
    always_comb begin
        next_addr_hi = addr_hi;
        next_addr_lo = addr_lo;
        if (wr_addr_hi && idle)
            next_addr_hi = DAT_I[7:0];
        if (wr_addr_lo && idle)
            next_addr_lo = DAT_I[15:0];
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            addr_hi <= ADDR_HI_RESET;
            addr_lo <= ADDR_LO_RESET;
        end else begin
            addr_hi <= next_addr_hi;
            addr_lo <= next_addr_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: the timer is loaded with count minus one so that the
    // operation lasts exactly the configured number of cycles
    always_comb begin
        next_state   = state;
        next_timer   = timer;
        next_control = control;
        if (wr_control && idle) begin
            next_control = DAT_I[15:0] & CONTROL_WRITABLE;
            // A refused start is flagged instead of running
            next_control[ERROR_BIT] = DAT_I[START_BIT] && !launch;
        end
        case (state)
            ST_IDLE: begin
                if (launch) begin
                    next_control[START_BIT] = 1'b1;
                    if (is_erase(DAT_I)) begin
                        next_state = ST_ERASE;
                        next_timer = 32'(ERASE_COUNT - 1);
                    end else begin
                        next_state = ST_PROGRAM;
                        next_timer = 32'(PROGRAM_COUNT - 1);
                    end
                end
            end
            ST_ERASE, ST_PROGRAM: begin
                if (finish) begin
                    next_state = ST_IDLE;
                    next_control[START_BIT] = 1'b0;
                end else begin
                    next_timer = timer - 32'h1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_timer = TIMER_RESET;
                next_control[START_BIT] = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state   <= ST_IDLE;
            timer   <= TIMER_RESET;
            control <= CONTROL_RESET;
        end else begin
            state   <= next_state;
            timer   <= next_timer;
            control <= next_control;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus reads; the key register always reads zero
    always_comb begin
        next_ack = access;
        next_dat = 32'h0;
        if (access && !WE_I) begin
            case (ADR_I)
                OFS_CONTROL: next_dat = {16'h0, control};
                OFS_KEY:     next_dat = 32'h0;
                OFS_ADDR_HI: next_dat = {24'h0, addr_hi};
                OFS_ADDR_LO: next_dat = {16'h0, addr_lo};
                default:     next_dat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0;
        end else begin
            ACK_O <= next_ack;
            DAT_O <= next_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign CPU_STALL     = !idle;
    assign FLASH_ERASE   = (state == ST_ERASE);
    assign FLASH_PROGRAM = (state == ST_PROGRAM);
    assign FLASH_ADDR    = target_address;

endmodule : flash_self_program_sequencer

/* nv_seq_pkg.sv */
/*
 Package for the flash self-programming sequencer: register word offsets,
 control field positions, key values, reset values and timing constants.
 Assumes a 32-bit classic Wishbone register bus with byte addressing.
*/
package nv_seq_pkg;
    // Word-aligned byte offsets of the registers
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_KEY     = 8'h04;
    localparam logic [7:0] OFS_ADDR_HI = 8'h08;
    localparam logic [7:0] OFS_ADDR_LO = 8'h0c;

    // Control register fields
    localparam int START_BIT  = 15;
    localparam int ENABLE_BIT = 14;
    localparam int ERROR_BIT  = 13;
    localparam int OP_LSB     = 0;
    localparam int OP_WIDTH   = 2;

    localparam logic [1:0] OP_PROGRAM = 2'h1;
    localparam logic [1:0] OP_ERASE   = 2'h2;

    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // Bits of the control register that software may store
    localparam logic [15:0] CONTROL_WRITABLE = 16'h4003;

    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [31:0] TIMER_RESET   = 32'h0;
    localparam logic [7:0]  ADDR_HI_RESET = 8'h00;
    localparam logic [15:0] ADDR_LO_RESET = 16'h0000;

    // Operation times in microseconds, converted to 100 MHz cycles
    localparam int CLK_MHZ          = 100;
    localparam int ERASE_TIME_US    = 20000;
    localparam int PROGRAM_TIME_US  = 50;
    localparam int ERASE_CYCLES     = ERASE_TIME_US * CLK_MHZ;
    localparam int PROGRAM_CYCLES   = PROGRAM_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_ERASE   = 3'b010,
        ST_PROGRAM = 3'b100
    } seq_state_e;

    typedef enum logic [2:0] {
        KEY_NONE  = 3'b001,
        KEY_HALF  = 3'b010,
        KEY_ARMED = 3'b100
    } key_state_e;
endpackage : nv_seq_pkg

/* seq_checker.sv */
/* Port assertions for the flash sequencer, bound into every instance.
   Assumes ERASE_COUNT near 20 and PROGRAM_COUNT near 8 in simulation. */
`timescale 1ns/100ps
module seq_checker (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic        ACK_O,
    input wire logic        CPU_STALL,
    input wire logic        FLASH_ERASE,
    input wire logic        FLASH_PROGRAM,
    input wire logic [23:0] FLASH_ADDR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////
    AST_STALL_TIES: assert property (CPU_STALL == (FLASH_ERASE || FLASH_PROGRAM))
        else $error("stall differs from running operation");
    AST_ONE_OP: assert property (!(FLASH_ERASE && FLASH_PROGRAM))
        else $error("erase and program together");
    AST_ACK_NEXT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("bus request not answered");
    AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    AST_START_WRITE: assert property ($rose(CPU_STALL) |-> ACK_O && $past(WE_I))
        else $error("operation began without a write");
    AST_ALIGN: assert property ($rose(FLASH_PROGRAM) |-> FLASH_ADDR[1:0] == 2'h2)
        else $error("program target misaligned");
    AST_ADDR_HELD: assert property (CPU_STALL |=> $stable(FLASH_ADDR))
        else $error("target moved while busy");
    AST_ERASE_MIN: assert property ($rose(FLASH_ERASE) |-> FLASH_ERASE[*8])
        else $error("erase ended early");
    AST_STALL_END: assert property ($rose(CPU_STALL) |-> ##[1:30] !CPU_STALL)
        else $error("stall never released");
    ////////////////////////////////////////////////////////////////////////
    cover property ($rose(FLASH_ERASE));
    cover property ($rose(FLASH_PROGRAM));
    cover property ($fell(CPU_STALL));
endmodule : seq_checker

bind flash_self_program_sequencer seq_checker u_checker (.CLK(CLK), .RST_N(RST_N),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ACK_O(ACK_O), .CPU_STALL(CPU_STALL),
    .FLASH_ERASE(FLASH_ERASE), .FLASH_PROGRAM(FLASH_PROGRAM), .FLASH_ADDR(FLASH_ADDR));

/* tb_flash_self_program_sequencer.sv */
/* Self-checking bench for the flash sequencer: Wishbone tasks and one task
   per scenario. Assumes short operation counts set at the instance. */
`timescale 1ns/100ps
module tb_flash_self_program_sequencer import nv_seq_pkg::*; ;
    logic        clk, rst_n, cyc, stb, we, ack, stall, fer, fpr;
    logic [7:0]  adr;
    logic [31:0] dat, dq, rdv;
    logic [23:0] fa;
    int          err_total, compares;
    // Short operations keep the run small; the logic does not depend on length
    localparam int ERASE_N   = 20;
    localparam int PROGRAM_N = 8;

    flash_self_program_sequencer #(.ERASE_COUNT(ERASE_N), .PROGRAM_COUNT(PROGRAM_N)) dut (
        .CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hf), .DAT_I(dat), .DAT_O(dq), .ACK_O(ack), .CPU_STALL(stall),
        .FLASH_ERASE(fer), .FLASH_PROGRAM(fpr), .FLASH_ADDR(fa));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        rdv = dq;
        {cyc, stb} <= 2'b00;
        chk("ack wait", 32'h2, n);
    endtask : wb

    task automatic launch(input logic [15:0] lo, input logic [31:0] ctl);
        wb(1'b1, OFS_ADDR_LO, {16'h0, lo});
        wb(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
        wb(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
        wb(1'b1, OFS_CONTROL, ctl);
        // Two idle slots after the start, as the processor would leave them
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : launch

    // Left is the number of falling edges from the call until stall drops
    task automatic done_wait(input int left);
        int n;
        n = 0;
        while (stall !== 1'b0) begin
            @(negedge clk);
            n++;
        end
        chk("busy cycles", left, n);
        chk("flash idle", 32'h0, {fer, fpr});
        wb(1'b0, OFS_CONTROL, 32'h0);
        chk("start cleared", 32'h0, rdv & 32'h8000);
    endtask : done_wait
    ////////////////////////////////////////////////////////////////////////
    task automatic s_regs();
        wb(1'b0, OFS_CONTROL, 32'h0);
        chk("control reset", {16'h0, CONTROL_RESET}, rdv);
        wb(1'b1, OFS_ADDR_HI, 32'h12);
        wb(1'b0, OFS_ADDR_HI, 32'h0);
        chk("addr high", 32'h12, rdv);
        wb(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
        wb(1'b0, OFS_KEY, 32'h0);
        chk("key read", 32'h0, rdv);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rdv);
    endtask : s_regs

    task automatic s_erase();
        launch(16'h0000, 32'hc002);
        chk("erase run", 32'h5, {fer, fpr, stall});
        chk("erase target", 32'h120000, fa);
        wb(1'b0, OFS_CONTROL, 32'h0);
        chk("busy bit", 32'h8000, rdv & 32'h8000);
        done_wait(ERASE_N - 5);
    endtask : s_erase

    task automatic s_program();
        launch(16'h0006, 32'hc001);
        chk("program run", 32'h3, {fer, fpr, stall});
        chk("program target", 32'h120006, fa);
        done_wait(PROGRAM_N - 3);
        wb(1'b1, OFS_CONTROL, 32'hc001);
        @(negedge clk);
        chk("key reuse", 32'h0, stall);
    endtask : s_program

    task automatic s_refused();
        logic [47:0] cs [3] = '{{16'h0004, 32'hc001}, {16'h0, 32'h8002}, {16'h2, 32'hc003}};
        foreach (cs[i]) begin
            launch(cs[i][47:32], cs[i][31:0]);
            chk("refused", 32'h0, stall);
            wb(1'b0, OFS_CONTROL, 32'h0);
            chk("error bit", 32'h2000, rdv & 32'ha000);
        end
        wb(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
        wb(1'b1, OFS_ADDR_LO, 32'h0);
        wb(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
        wb(1'b1, OFS_CONTROL, 32'hc002);
        @(negedge clk);
        chk("broken key", 32'h0, stall);
    endtask : s_refused

    // Reset in the middle of an erase must drop the stall and clear the registers
    task automatic s_reset_mid();
        launch(16'h0000, 32'hc002);
        chk("erase before reset", 32'h1, stall);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk("outputs in reset", 32'h0, {fer, fpr, stall});
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, OFS_CONTROL, 32'h0);
        chk("control after reset", {16'h0, CONTROL_RESET}, rdv);
        wb(1'b0, OFS_ADDR_HI, 32'h0);
        chk("addr high after reset", {24'h0, ADDR_HI_RESET}, rdv);
    endtask : s_reset_mid

    task automatic results();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, cyc, stb, we, adr, dat} <= '0;
        err_total = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_erase();
        s_program();
        s_refused();
        s_reset_mid();
        results();
    end

    // Run needs about 180 cycles
    initial begin
        #20us;
        err_total++;
        results();
    end
endmodule : tb_flash_self_program_sequencer
